/* common/jdp_pkg.sv */
// Constants, register map and types of the serial link data path
//------------------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------------------
package jdp_pkg;

  //----------------------------------------------------------------------------
  // Register byte addresses
  //----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_DELAY  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0c;

  //----------------------------------------------------------------------------
  // Field positions
  //----------------------------------------------------------------------------
  localparam int DLY_XCVR_BIT   = 6;
  localparam int DLY_INV_BIT    = 5;
  localparam int CTRL_IRQ_BIT   = 0;
  localparam int CTRL_LOOP_BIT  = 1;
  localparam int CTRL_EOD_BIT   = 2;
  localparam int CTRL_RESP_BIT  = 3;
  localparam int ST_TXE_BIT     = 0;
  localparam int ST_RXF_BIT     = 1;
  localparam int ST_RESP_BIT    = 2;
  localparam int ST_INV_BIT     = 3;
  localparam int ST_BUSY_BIT    = 4;

  //----------------------------------------------------------------------------
  // Reset values and timing
  //----------------------------------------------------------------------------
  localparam logic [3:0] DELAY_OFFSET_RST = 4'h7;
  localparam logic [7:0] DELAY_REG_RST    = 8'h27;
  localparam int         DELAY_BASE_US    = 9;
  localparam int         CLK_MHZ          = 10;
  localparam int         BIT_TIME_US      = 64;
  localparam int         BIT_CYCLES       = BIT_TIME_US * CLK_MHZ;
  localparam logic [3:0] EXTRA_ONES       = 4'h2;

  // Transmit sequencer states
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_SHIFT = 4'b0010,
    TX_PAD   = 4'b0100,
    TX_HALT  = 4'b1000
  } jdp_tx_state_t;

endpackage : jdp_pkg

/* logic/jdp_data_path.sv */
// Data path: double-buffered byte transfer, delay setup, loopback, APB slave
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module jdp_data_path #(
  parameter int BIT_CYC = jdp_pkg::BIT_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_phy_input,
  output logic             tx_phy_output,
  output logic             irq_req,
  output logic [4:0]       expected_delay_us,
  output logic             onchip_xcvr_select
);
  import jdp_pkg::*;

  //----------------------------------------------------------------------------
  // State record
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]    txShadow;
    logic          txShadowFull;
    logic [7:0]    txShift;
    logic [2:0]    txCount;
    logic [3:0]    padCount;
    logic [15:0]   bitTimer;
    jdp_tx_state_t txState;
    logic          txOut;
    logic [7:0]    rxShift;
    logic [2:0]    rxCount;
    logic [7:0]    rxShadow;
    logic          rxPrev;
    logic          txEmpty;
    logic          rxFull;
    logic          rxResp;
    logic          invalidSym;
    logic          statusSeen;
    logic [7:0]    delayReg;
    logic          delayLocked;
    logic [3:0]    ctrl;
    logic          irq;
    logic [31:0]   rdata;
  } jdp_state_t;

  jdp_state_t cur;
  jdp_state_t next_cur;

  logic access;
  logic rdSetup;
  logic wrEn;
  logic rdEn;
  logic rxLine;
  logic bitTick;
  logic rxBit;

  // Single-cycle access phase; zero wait states, so read data is fetched in setup
  assign access  = psel & penable & clk_en;
  assign rdSetup = psel & ~penable & ~pwrite & clk_en;
  assign wrEn    = access & pwrite;
  assign rdEn    = access & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Loopback picks the internal transmit line before polarity correction
  assign rxLine  = cur.ctrl[CTRL_LOOP_BIT] ? cur.txOut : rx_phy_input;
  assign rxBit   = cur.delayReg[DLY_INV_BIT] ? rxLine : ~rxLine;
  assign bitTick = (cur.bitTimer == 16'(BIT_CYC - 1));

  // Outputs straight from flip-flops, except expected_delay_us, which adds DELAY_BASE_US to the delay code
  assign prdata             = cur.rdata;
  assign tx_phy_output      = cur.txOut;
  assign irq_req            = cur.irq;
  assign onchip_xcvr_select = cur.delayReg[DLY_XCVR_BIT];
  assign expected_delay_us  = 5'(DELAY_BASE_US) + {1'b0, cur.delayReg[3:0]};

  //----------------------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.irq = 1'b0;
    next_cur.bitTimer = bitTick ? 16'h0000 : cur.bitTimer + 16'h0001;

    // Register writes
    if (wrEn)
    begin
      unique case (paddr)
        ADDR_DATA:
        begin
          next_cur.txShadow     = pwdata[7:0];
          next_cur.txShadowFull = 1'b1;
          if (cur.statusSeen)
          begin
            next_cur.txEmpty    = 1'b0;
            next_cur.statusSeen = 1'b0;
          end
        end
        ADDR_DELAY:
        begin
          // Later writes are dropped so a stray store cannot retune timing
          if (!cur.delayLocked)
          begin
            next_cur.delayReg    = {1'b0, pwdata[6:0]};
            next_cur.delayLocked = 1'b1;
          end
        end
        ADDR_CTRL:
        begin
          next_cur.ctrl = pwdata[3:0];
          if (pwdata[CTRL_EOD_BIT])
            next_cur.txEmpty = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    // Read data latched in setup so it stands when pready is sampled; unmapped reads zero
    if (rdSetup)
    begin
      unique case (paddr)
        ADDR_DATA:
          next_cur.rdata = {24'h000000, cur.rxShadow};
        ADDR_DELAY:
          next_cur.rdata = {24'h000000, cur.delayReg};
        ADDR_STATUS:
          next_cur.rdata = {27'h0000000, cur.txState != TX_IDLE, cur.invalidSym,
                            cur.rxResp, cur.rxFull, cur.txEmpty};
        ADDR_CTRL:
          next_cur.rdata = {28'h0000000, cur.ctrl};
        default:
          next_cur.rdata = 32'h00000000;
      endcase
    end

    // Read side effects only at the access edge
    if (rdEn)
    begin
      if (paddr == ADDR_DATA && cur.statusSeen)
      begin
        next_cur.rxFull     = 1'b0;
        next_cur.rxResp     = 1'b0;
        next_cur.statusSeen = 1'b0;
      end
      if (paddr == ADDR_STATUS)
      begin
        next_cur.statusSeen = 1'b1;
        // Only a reported error is cleared, one raised after setup survives
        next_cur.invalidSym = cur.invalidSym & ~cur.rdata[ST_INV_BIT];
      end
    end

    // Transmit sequencer, one bit per bit time
    if (bitTick)
    begin
      unique case (cur.txState)
        TX_IDLE:
        begin
          next_cur.txOut = 1'b1;
          if (cur.txShadowFull)
          begin
            next_cur.txShift      = cur.txShadow;
            next_cur.txShadowFull = 1'b0;
            next_cur.txCount      = 3'h0;
            next_cur.txState      = TX_SHIFT;
          end
        end
        TX_SHIFT:
        begin
          next_cur.txOut   = cur.txShift[7];
          next_cur.txShift = {cur.txShift[6:0], 1'b0};
          next_cur.txCount = cur.txCount + 3'h1;
          if (cur.txCount == 3'h0)
            next_cur.txEmpty = 1'b1;
          if (cur.txCount == 3'h7)
          begin
            if (cur.txShadowFull)
            begin
              next_cur.txShift      = cur.txShadow;
              next_cur.txShadowFull = 1'b0;
            end
            else if (cur.ctrl[CTRL_EOD_BIT])
              next_cur.txState = TX_IDLE;
            else
            begin
              next_cur.padCount = 4'h0;
              next_cur.txState  = TX_PAD;
            end
          end
        end
        TX_PAD:
        begin
          // Underrun: two ones land off the byte boundary, then stop
          next_cur.txOut    = 1'b1;
          next_cur.padCount = cur.padCount + 4'h1;
          if (cur.padCount == EXTRA_ONES - 4'h1)
            next_cur.txState = TX_HALT;
        end
        TX_HALT:
        begin
          next_cur.invalidSym = 1'b1;
          next_cur.txState    = TX_IDLE;
        end
        default:
          next_cur.txState = TX_IDLE;
      endcase

      // Receive shift: sample one bit per bit time
      if (cur.txState != TX_IDLE || cur.ctrl[CTRL_LOOP_BIT] == 1'b0)
      begin
        next_cur.rxShift = {cur.rxShift[6:0], rxBit};
        next_cur.rxCount = cur.rxCount + 3'h1;
        if (cur.rxCount == 3'h7)
        begin
          next_cur.rxShadow = {cur.rxShift[6:0], rxBit};
          if (cur.ctrl[CTRL_RESP_BIT])
            next_cur.rxResp = 1'b1;
          else
            next_cur.rxFull = 1'b1;
          next_cur.irq = cur.ctrl[CTRL_IRQ_BIT];
        end
      end
    end
    next_cur.rxPrev = rxBit;
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur          <= '0;
      cur.txState  <= TX_IDLE;
      cur.txOut    <= 1'b1;
      cur.delayReg <= DELAY_REG_RST;
    end
    else if (clk_en)
      cur <= next_cur;
  end

endmodule : jdp_data_path

/* verification/jdp_data_path_properties.sv */
// Port-level assertions for the serial data path, bound to the design
`timescale 1ns/100ps
module jdp_data_path_properties #(
  parameter int BIT_CYC = 4
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_phy_output,
  input wire logic        irq_req,
  input wire logic [4:0]  expected_delay_us,
  input wire logic        onchip_xcvr_select
);
  import jdp_pkg::*;
  //----------------------------------------------------------------
  // Shadow of interrupt enable and the one-shot delay write
  //----------------------------------------------------------------
  logic wrTaken, rdTaken, irqAllow, dlyDone;
  assign wrTaken = psel && penable && clk_en && pwrite;
  assign rdTaken = psel && penable && clk_en && !pwrite;
  // Follows taken writes only, so a refused access leaves it alone
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) {irqAllow, dlyDone} <= 2'b00;
    else if (wrTaken && paddr == ADDR_CTRL) irqAllow <= pwdata[CTRL_IRQ_BIT];
    else if (wrTaken && paddr == ADDR_DELAY) dlyDone <= 1'b1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_irq_mask; irq_req |-> irqAllow; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled");
  property p_irq_pulse; irq_req && clk_en |=> !irq_req; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
  property p_dly_rst; !dlyDone |-> expected_delay_us == 5'h10; endproperty
  a_dly_rst: assert property (p_dly_rst) else $error("default delay wrong");
  property p_dly_first; wrTaken && paddr == ADDR_DELAY && !dlyDone |=> expected_delay_us ==
    {1'b0, $past(pwdata[3:0])} + 5'h09 && onchip_xcvr_select == $past(pwdata[DLY_XCVR_BIT]); endproperty
  a_dly_first: assert property (p_dly_first) else $error("delay code not applied");
  property p_dly_once; dlyDone |=> $stable(expected_delay_us) && $stable(onchip_xcvr_select); endproperty
  a_dly_once: assert property (p_dly_once) else $error("delay changed after first write");
  property p_dly_read; rdTaken && paddr == ADDR_DELAY |-> {1'b0, prdata[3:0]} + 5'h09 == expected_delay_us
    && prdata[DLY_XCVR_BIT] == onchip_xcvr_select; endproperty
  a_dly_read: assert property (p_dly_read) else $error("delay readback wrong");
  // Three further cycles fit the four-clock bit time used in simulation
  property p_tx_hold; $changed(tx_phy_output) |=> $stable(tx_phy_output) [*3]; endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx bit shorter than a bit time");
  property p_ready; psel && penable |-> pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("access not answered cleanly");
endmodule : jdp_data_path_properties
bind jdp_data_path jdp_data_path_properties #(.BIT_CYC(BIT_CYC)) jdp_data_path_properties_inst (.*);

/* verification/jdp_bus_model.sv */
// Bus-side partner that drives serial bytes onto the receive line
`timescale 1ns/100ps
module jdp_bus_model #(
  parameter int BIT_CYC = 4
) (
  input  wire logic core_clk,
  input  wire logic tx_phy_output,
  output logic      rx_phy_input
);
  //----------------------------------------------------------------
  // Serial source
  //----------------------------------------------------------------
  // Released line rests high, as the bus idles recessive
  initial rx_phy_input = 1'b1;
  // MSB first, non-inverted, each bit held one whole bit time
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      rx_phy_input <= b[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
    rx_phy_input <= 1'b1;
  endtask : send_byte
endmodule : jdp_bus_model

/* verification/tb_top.sv */
// Self-checking bench for the serial data path
`timescale 1ns/100ps
module tb_top;
  import jdp_pkg::*;
  //----------------------------------------------------------------
  // Stimulus, checks and report
  //----------------------------------------------------------------
  localparam int BC = 4;
  logic core_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr;
  logic rx_phy_input, tx_phy_output, irq_req, onchip_xcvr_select;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [4:0] expected_delay_us;
  int error_cnt, check_count;
  jdp_data_path #(.BIT_CYC(BC)) jdp_data_path_inst (.core_clk, .rst_n, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_phy_input, .tx_phy_output, .irq_req,
    .expected_delay_us, .onchip_xcvr_select);
  jdp_bus_model #(.BIT_CYC(BC)) jdp_bus_model_inst (.core_clk, .tx_phy_output, .rx_phy_input);
  // 10 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // Wait that ran out counts as a mismatch and ends the run
  task automatic hang;
    error_cnt++;
    end_of_test;
  endtask : hang
  // APB transfer; read data is taken at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, addr, data};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) hang;
    rdVal = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wait_irq;
    int n;
    n = 0;
    do @(posedge core_clk); while (irq_req !== 1'b1 && ++n < 200);
    if (n >= 200) hang;
  endtask : wait_irq
  task automatic test_delay;
    apb(1'b0, ADDR_DELAY, 32'h0);
    chk(rdVal, 32'h27, "delay reset value");
    chk(expected_delay_us, 32'h10, "default delay");
    apb(1'b1, ADDR_DELAY, 32'h2f);
    apb(1'b1, ADDR_DELAY, 32'h40);
    apb(1'b0, ADDR_DELAY, 32'h0);
    chk(rdVal, 32'h2f, "second write ignored");
    chk(expected_delay_us, 32'h18, "delay for top code");
    chk(onchip_xcvr_select, 32'h0, "off-chip transceiver");
    $display("test_delay done");
  endtask : test_delay
  // Sync to a byte end, then send on the bit grid
  task automatic test_rx;
    apb(1'b1, ADDR_CTRL, 32'h1);
    wait_irq;
    jdp_bus_model_inst.send_byte(8'ha5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdVal[ST_RXF_BIT], 32'h1, "rx full");
    apb(1'b0, ADDR_DATA, 32'h0);
    chk(rdVal[7:0], 32'ha5, "rx byte");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdVal[ST_RXF_BIT], 32'h0, "rx full clear");
    wait_irq;
    jdp_bus_model_inst.send_byte(8'h5a);
    jdp_bus_model_inst.send_byte(8'h3c);
    apb(1'b0, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_DATA, 32'h0);
    chk(rdVal[7:0], 32'h3c, "unread byte overwritten");
    $display("test_rx done");
  endtask : test_rx
  // Two bytes back to back, then underrun
  task automatic test_tx;
    int n;
    logic [15:0] bits;
    bits = 16'h5a96;
    apb(1'b1, ADDR_DATA, 32'h5a);
    n = 0;
    do @(posedge core_clk); while (tx_phy_output !== 1'b0 && ++n < 200);
    if (n >= 200) hang;
    @(posedge core_clk);
    fork
      for (int i = 15; i >= 0; i--)
      begin
        chk(tx_phy_output, bits[i], "tx bit");
        repeat (BC) @(posedge core_clk);
      end
      begin
        repeat (BC) @(posedge core_clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rdVal[ST_TXE_BIT], 32'h1, "tx empty");
        apb(1'b1, ADDR_DATA, 32'h96);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rdVal[ST_TXE_BIT], 32'h0, "tx empty clear");
      end
    join
    repeat (8 * BC) @(posedge core_clk);
    chk(tx_phy_output, 32'h1, "tx halted high");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdVal[ST_INV_BIT], 32'h1, "underrun reported");
    $display("test_tx done");
  endtask : test_tx
  // Reset, then the scenarios in turn
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    test_delay;
    test_rx;
    test_tx;
    end_of_test;
  end
endmodule : tb_top
